/* ldbc_ctrl.sv */
// Regulator and boost converter control with two-wire serial register access
// Function
// - Offset 0 bit 0 turns the linear regulator on; resets off.
// - Five-bit voltage code: 1.8 V plus 50 mV per step; resets zero.
// - After converter enable, hold soft-start current limit 500 us, then normal, or reduced if control two bit 3 is set.
// - Auto feedback picks the high-voltage sink with lowest voltage.
// - Source code 00 regulates on feedback pin; other codes pick a sink.
// - Current feedback with protection: stop switching while pin exceeds 1.25 V.
// - Tuning current on feedback pin settable 0 to 31 uA, 1 uA steps.
// - Control two bit 0 selects feedback gain; resets zero.
// - Control two bit 1 selects pulse-skipping ripple behaviour; resets zero.
// - Control two bit 2 enables feedback pin over-voltage protection; resets one.
// - Control two bit 3 chooses coil current limit; zero is normal.
// - Coil limit bit set gives a limit about one third lower.
// - Auto feedback uses only enabled sinks not supplied by the pump.
module ldbc_ctrl #(
    parameter int SS_CYCLES = ldbc_pkg::SS_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        serial_clk_in,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe_n_out,
    input  wire logic        boost_enable_in,
    input  wire logic [1:0]  boost_feedback_source_in,
    input  wire logic        boost_feedback_autoselect_in,
    input  wire logic [4:0]  tuning_current_code_in,
    input  wire logic [5:0]  sink_operating_setting_in,
    input  wire logic [2:0]  sink_pump_supplied_flag_in,
    input  wire logic [23:0] hv_sink_mv_in,
    input  wire logic        boost_feedback_pin_over_in,
    output logic             linreg_enable_out,
    output logic      [4:0]  linreg_voltage_code_out,
    output logic      [11:0] linreg_voltage_mv_out,
    output logic             boost_gain_divider_out,
    output logic             boost_skip_elevated_out,
    output logic             boost_ovp_enable_out,
    output logic             boost_lowcur_out,
    output logic      [1:0]  boost_current_limit_out,
    output logic             soft_start_active_out,
    output logic             boost_switch_enable_out,
    output logic      [1:0]  boost_feedback_select_out,
    output logic      [4:0]  tuning_current_ua_out
);
    localparam int SSW = $clog2(SS_CYCLES + 1);
    localparam logic [SSW-1:0] SS_LAST = SSW'(SS_CYCLES - 1);

    // Address match used by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // =====================================================================
    // Serial pin edges and bus conditions
    logic        scl_q_ff;
    logic        sda_q_ff;
    wire         scl_rise  = serial_clk_in && !scl_q_ff;
    wire         scl_fall  = !serial_clk_in && scl_q_ff;
    wire         bus_start = serial_clk_in && scl_q_ff && sda_q_ff && !serial_data_in;
    wire         bus_stop  = serial_clk_in && scl_q_ff && !sda_q_ff && serial_data_in;

    // Serial engine state
    ldbc_pkg::ldbc_state_t state_ff;
    logic [3:0]  cnt_ff;
    logic [7:0]  sh_ff;
    logic [7:0]  ptr_ff;
    logic        rw_ff;
    logic        drive_ff;
    logic        ack_ok_ff;

    // Register storage
    logic [7:0]  reg_enable_ff;
    logic [4:0]  reg_volt_ff;
    logic [3:0]  reg_two_ff;

    // =====================================================================
    // Write strobe and read data
    wire         byte_done = (cnt_ff == ldbc_pkg::BYTE_BITS);
    wire         wr_en     = (state_ff == ldbc_pkg::ST_WR) && scl_fall && byte_done && !bus_start && !bus_stop;
    wire         we_enable = wr_en && hit(ptr_ff, ldbc_pkg::OFF_REG_ENABLE);
    wire         we_volt   = wr_en && hit(ptr_ff, ldbc_pkg::OFF_REG_VOLT);
    wire         we_two    = wr_en && hit(ptr_ff, ldbc_pkg::OFF_BOOST_TWO);
    wire [7:0]   rd_val    = hit(ptr_ff, ldbc_pkg::OFF_REG_ENABLE) ? reg_enable_ff :
                             hit(ptr_ff, ldbc_pkg::OFF_REG_VOLT)   ? {3'h0, reg_volt_ff} :
                             hit(ptr_ff, ldbc_pkg::OFF_BOOST_TWO)  ? {4'h0, reg_two_ff} :
                             ldbc_pkg::READ_ZERO;

    // Open-drain data pin, pulled low only
    assign serial_data_out      = 1'b0;
    assign serial_data_oe_n_out = !drive_ff;

    // Pin history
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= serial_clk_in;
            sda_q_ff <= serial_data_in;
        end
    end

    // =====================================================================
    // Serial transfer engine; held idle throughout reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff  <= ldbc_pkg::ST_IDLE;
            cnt_ff    <= 4'h0;
            sh_ff     <= 8'h00;
            ptr_ff    <= 8'h00;
            rw_ff     <= 1'b0;
            drive_ff  <= 1'b0;
            ack_ok_ff <= 1'b0;
        end else if (bus_start) begin
            state_ff <= ldbc_pkg::ST_DEV;
            cnt_ff   <= 4'h0;
            drive_ff <= 1'b0;
        end else if (bus_stop) begin
            state_ff <= ldbc_pkg::ST_IDLE;
            drive_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ldbc_pkg::ST_IDLE: begin
                    drive_ff <= 1'b0;
                end
                ldbc_pkg::ST_DEV, ldbc_pkg::ST_REG, ldbc_pkg::ST_WR: begin
                    if (scl_rise && !byte_done) begin
                        sh_ff  <= {sh_ff[6:0], serial_data_in};
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        drive_ff <= 1'b1;
                        if (state_ff == ldbc_pkg::ST_DEV) begin
                            rw_ff    <= sh_ff[0];
                            state_ff <= (sh_ff[7:1] == ldbc_pkg::DEV_ADDR) ? ldbc_pkg::ST_ACK_DEV
                                                                          : ldbc_pkg::ST_IDLE;
                            drive_ff <= (sh_ff[7:1] == ldbc_pkg::DEV_ADDR);
                        end else if (state_ff == ldbc_pkg::ST_REG) begin
                            ptr_ff   <= sh_ff;
                            state_ff <= ldbc_pkg::ST_ACK_REG;
                        end else begin
                            state_ff <= ldbc_pkg::ST_ACK_WR;
                        end
                    end
                end
                ldbc_pkg::ST_ACK_DEV: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            sh_ff    <= {rd_val[6:0], 1'b0};
                            drive_ff <= !rd_val[7];
                            cnt_ff   <= 4'h1;
                            state_ff <= ldbc_pkg::ST_RD;
                        end else begin
                            drive_ff <= 1'b0;
                            cnt_ff   <= 4'h0;
                            state_ff <= ldbc_pkg::ST_REG;
                        end
                    end
                end
                ldbc_pkg::ST_ACK_REG, ldbc_pkg::ST_ACK_WR: begin
                    if (scl_fall) begin
                        drive_ff <= 1'b0;
                        cnt_ff   <= 4'h0;
                        state_ff <= ldbc_pkg::ST_WR;
                        if (state_ff == ldbc_pkg::ST_ACK_WR) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end
                end
                ldbc_pkg::ST_RD: begin
                    if (scl_fall && byte_done) begin
                        drive_ff <= 1'b0;
                        state_ff <= ldbc_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        drive_ff <= !sh_ff[7];
                        sh_ff    <= {sh_ff[6:0], 1'b0};
                        cnt_ff   <= cnt_ff + 4'h1;
                    end
                end
                ldbc_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        ack_ok_ff <= !serial_data_in;
                        if (!serial_data_in) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end else if (scl_fall) begin
                        if (ack_ok_ff) begin
                            sh_ff    <= {rd_val[6:0], 1'b0};
                            drive_ff <= !rd_val[7];
                            cnt_ff   <= 4'h1;
                            state_ff <= ldbc_pkg::ST_RD;
                        end else begin
                            state_ff <= ldbc_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // Register file
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_enable_ff <= ldbc_pkg::RST_REG_ENABLE;
            reg_volt_ff   <= ldbc_pkg::RST_REG_VOLT;
            reg_two_ff    <= ldbc_pkg::RST_BOOST_TWO;
        end else begin
            if (we_enable) begin
                reg_enable_ff <= sh_ff;
            end
            if (we_volt) begin
                reg_volt_ff <= sh_ff[ldbc_pkg::VOLT_MSB:0];
            end
            if (we_two) begin
                reg_two_ff <= sh_ff[ldbc_pkg::BOOST_TWO_MSB:0];
            end
        end
    end

    // Register fields onto control outputs
    assign linreg_enable_out       = reg_enable_ff[ldbc_pkg::BIT_LINREG_ON];
    assign linreg_voltage_code_out = reg_volt_ff;
    assign boost_gain_divider_out  = reg_two_ff[ldbc_pkg::BIT_GAIN_DIV];
    assign boost_skip_elevated_out = reg_two_ff[ldbc_pkg::BIT_SKIP_FAST];
    assign boost_ovp_enable_out    = reg_two_ff[ldbc_pkg::BIT_OVP_EN];
    assign boost_lowcur_out        = reg_two_ff[ldbc_pkg::BIT_LOWCUR];

    // =====================================================================
    // Soft start, current limit, switching gate
    logic            en_q_ff;
    logic [SSW-1:0]  ss_cnt_ff;
    wire             cur_mode = (boost_feedback_source_in != ldbc_pkg::FB_PIN) || boost_feedback_autoselect_in;
    wire             ovp_trip = cur_mode && boost_ovp_enable_out && boost_feedback_pin_over_in;
    wire [11:0]      nxt_mv   = ldbc_pkg::LDO_BASE_MV + ldbc_pkg::LDO_STEP_MV * {7'h00, reg_volt_ff};
    wire [1:0]       nxt_limit = soft_start_active_out ? ldbc_pkg::LIM_SOFT :
                                 boost_lowcur_out      ? ldbc_pkg::LIM_REDUCED :
                                 ldbc_pkg::LIM_NORMAL;

    // Timer reloads on each enable rise, ends on count or disable
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            en_q_ff               <= 1'b0;
            ss_cnt_ff             <= '0;
            soft_start_active_out <= 1'b0;
        end else begin
            en_q_ff <= boost_enable_in;
            if (boost_enable_in && !en_q_ff) begin
                ss_cnt_ff             <= '0;
                soft_start_active_out <= 1'b1;
            end else if (!boost_enable_in || ss_cnt_ff == SS_LAST) begin
                soft_start_active_out <= 1'b0;
            end else if (soft_start_active_out) begin
                ss_cnt_ff <= ss_cnt_ff + SSW'(1);
            end
        end
    end

    // Registered analog-facing outputs
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            linreg_voltage_mv_out   <= ldbc_pkg::LDO_BASE_MV;
            boost_current_limit_out <= ldbc_pkg::LIM_NORMAL;
            boost_switch_enable_out <= 1'b0;
            tuning_current_ua_out   <= 5'h00;
        end else begin
            linreg_voltage_mv_out   <= nxt_mv;
            boost_current_limit_out <= nxt_limit;
            boost_switch_enable_out <= boost_enable_in && !ovp_trip;
            tuning_current_ua_out   <= tuning_current_code_in;
        end
    end

    // Feedback source choice
    ldbc_fb_select u_fb_select (
        .clock_in      (clock_in),
        .sys_rst_in    (sys_rst_in),
        .autoselect_in (boost_feedback_autoselect_in),
        .source_in     (boost_feedback_source_in),
        .sink_mode_in  (sink_operating_setting_in),
        .sink_pump_in  (sink_pump_supplied_flag_in),
        .sink_mv_in    (hv_sink_mv_in),
        .select_out    (boost_feedback_select_out)
    );

    // =====================================================================
    // Checks
    chk_linreg_on_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        we_enable |=> (linreg_enable_out == $past(sh_ff[0])))
        else $error("regulator enable not taken from write");
    chk_volt_mv_map: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        we_volt |=> ##1 (linreg_voltage_mv_out == 12'h708 + 12'h032 * {7'h00, $past(sh_ff[4:0], 2)}))
        else $error("regulator millivolt mapping wrong");
    chk_soft_start_go: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        $rose(boost_enable_in) |=> soft_start_active_out ##1 (boost_current_limit_out == ldbc_pkg::LIM_SOFT))
        else $error("soft start not begun on enable");
    chk_soft_start_len: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ($fell(soft_start_active_out) && $past(boost_enable_in)) |-> ($past(ss_cnt_ff) == SS_LAST))
        else $error("soft start ended at wrong count");
    chk_ovp_stop: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (boost_enable_in && cur_mode && boost_ovp_enable_out && boost_feedback_pin_over_in) |=> !boost_switch_enable_out)
        else $error("switching not stopped on over-voltage");
    chk_ovp_resume: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (boost_enable_in && !boost_feedback_pin_over_in) |=> boost_switch_enable_out)
        else $error("switching not resumed below threshold");
    chk_tuning_copy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        1'b1 |=> (tuning_current_ua_out == $past(tuning_current_code_in)))
        else $error("tuning current not applied");
    chk_ctrl_two_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        we_two |=> (boost_ovp_enable_out == $past(sh_ff[2])) && (boost_gain_divider_out == $past(sh_ff[0])))
        else $error("control two fields not updated");
    chk_lowcur_limit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (boost_lowcur_out && !soft_start_active_out) |=> (boost_current_limit_out == ldbc_pkg::LIM_REDUCED))
        else $error("reduced coil limit not applied");
endmodule : ldbc_ctrl

/* ldbc_pkg.sv */
// Shared constants for the regulator and boost converter control block
package ldbc_pkg;
    // =====================================================================
    // Register offsets
    localparam logic [7:0] OFF_REG_ENABLE = 8'h00;
    localparam logic [7:0] OFF_REG_VOLT   = 8'h07;
    localparam logic [7:0] OFF_BOOST_TWO  = 8'h22;

    // =====================================================================
    // Field positions
    localparam int BIT_LINREG_ON   = 0;
    localparam int VOLT_MSB        = 4;
    localparam int BIT_GAIN_DIV    = 0;
    localparam int BIT_SKIP_FAST   = 1;
    localparam int BIT_OVP_EN      = 2;
    localparam int BIT_LOWCUR      = 3;
    localparam int BOOST_TWO_MSB   = 3;

    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_REG_ENABLE = 8'h00;
    localparam logic [4:0] RST_REG_VOLT   = 5'h00;
    localparam logic [3:0] RST_BOOST_TWO  = 4'h4;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // =====================================================================
    // Regulator voltage mapping in millivolts
    localparam logic [11:0] LDO_BASE_MV = 12'h708;
    localparam logic [11:0] LDO_STEP_MV = 12'h032;

    // =====================================================================
    // Feedback source codes
    localparam logic [1:0] FB_PIN    = 2'h0;
    localparam logic [1:0] FB_SINK_A = 2'h1;
    localparam logic [1:0] FB_SINK_B = 2'h2;
    localparam logic [1:0] FB_SINK_C = 2'h3;
    localparam logic [1:0] SINK_OFF  = 2'h0;

    // =====================================================================
    // Current limit levels
    localparam logic [1:0] LIM_NORMAL  = 2'h0;
    localparam logic [1:0] LIM_SOFT    = 2'h1;
    localparam logic [1:0] LIM_REDUCED = 2'h2;

    // =====================================================================
    // Timing
    localparam int CLK_MHZ      = 10;
    localparam int SS_TIME_US   = 500;
    localparam int SS_CYCLES    = SS_TIME_US * CLK_MHZ;

    // =====================================================================
    // Serial interface
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [6:0] DEV_ADDR  = 7'h2a;  // Arbitrary value

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_ACK_DEV, ST_REG, ST_ACK_REG,
        ST_WR, ST_ACK_WR, ST_RD, ST_RACK
    } ldbc_state_t;
endpackage : ldbc_pkg

/* ldbc_fb_select.sv */
// Automatic feedback choice among the three high-voltage sinks
module ldbc_fb_select (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        autoselect_in,
    input  wire logic [1:0]  source_in,
    input  wire logic [5:0]  sink_mode_in,
    input  wire logic [2:0]  sink_pump_in,
    input  wire logic [23:0] sink_mv_in,
    output logic      [1:0]  select_out
);
    // =====================================================================
    // Eligibility of each sink
    logic [2:0] elig;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_elig
            assign elig[gi] = (sink_mode_in[2*gi+1:2*gi] != ldbc_pkg::SINK_OFF)
                              && !sink_pump_in[gi];
        end
    endgenerate

    // Voltage of the sink named by a select code
    function automatic logic [7:0] mv_of(input logic [1:0] sel, input logic [23:0] bus);
        mv_of = (sel == ldbc_pkg::FB_SINK_A) ? bus[7:0] :
                (sel == ldbc_pkg::FB_SINK_B) ? bus[15:8] : bus[23:16];
    endfunction : mv_of

    // =====================================================================
    // Lowest-voltage search
    wire        pick_a  = elig[0] && (!elig[1] || sink_mv_in[7:0] <= sink_mv_in[15:8]);
    wire [1:0]  idx_ab  = pick_a ? ldbc_pkg::FB_SINK_A : ldbc_pkg::FB_SINK_B;
    wire [7:0]  mv_ab   = pick_a ? sink_mv_in[7:0] : sink_mv_in[15:8];
    wire        e_ab    = elig[0] || elig[1];
    wire        pick_ab = e_ab && (!elig[2] || mv_ab <= sink_mv_in[23:16]);
    wire [1:0]  best    = pick_ab ? idx_ab : ldbc_pkg::FB_SINK_C;
    wire        auto_hit = autoselect_in && (source_in != ldbc_pkg::FB_PIN) && (|elig);
    wire [1:0]  nxt_select = auto_hit ? best : source_in;

    // Registered selection
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            select_out <= ldbc_pkg::FB_PIN;
        end else begin
            select_out <= nxt_select;
        end
    end

    // =====================================================================
    // Checks on the automatic choice
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chk
            chk_auto_lowest_v: assert property (@(posedge clock_in) disable iff (sys_rst_in)
                (auto_hit && elig[gi]) |=> ($past(sink_mv_in[8*gi+7:8*gi]) >= mv_of(select_out, $past(sink_mv_in))))
                else $error("auto feedback did not pick lowest sink");
            chk_auto_skip_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
                (auto_hit && !elig[gi]) |=> (select_out != 2'(gi + 1)))
                else $error("auto feedback picked ineligible sink");
        end
    endgenerate
    chk_pin_feedback: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (source_in == ldbc_pkg::FB_PIN) |=> (select_out == ldbc_pkg::FB_PIN))
        else $error("pin feedback not selected for code zero");
endmodule : ldbc_fb_select

/* tb_ldbc_ctrl.sv */
// Self-checking testbench for the regulator and boost converter control block
module tb_ldbc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Stimulus, wire level and device under test
    localparam int SS = 20;
    logic        clk, rst, scl, sda_m, en, auto_sel, over, oe_n, sd_o, ldo_en, gain, skip, ovp, lowc, ss_act, sw;
    logic [1:0]  src, lim, sel;
    logic [4:0]  tune, code, ua;
    logic [5:0]  mode;
    logic [2:0]  pump;
    logic [23:0] mv;
    logic [11:0] mvo;
    logic [7:0]  v0, v7, v22, r;
    logic        a;
    int          err_count, num_checks, cyc;
    wire         sda_w = sda_m & (oe_n | sd_o);  // Open-drain data line with pull-up
    ldbc_ctrl #(.SS_CYCLES(SS)) dut (.clock_in(clk), .sys_rst_in(rst), .serial_clk_in(scl), .serial_data_in(sda_w),
        .serial_data_out(sd_o), .serial_data_oe_n_out(oe_n), .boost_enable_in(en), .boost_feedback_source_in(src),
        .boost_feedback_autoselect_in(auto_sel), .tuning_current_code_in(tune), .sink_operating_setting_in(mode),
        .sink_pump_supplied_flag_in(pump), .hv_sink_mv_in(mv), .boost_feedback_pin_over_in(over),
        .linreg_enable_out(ldo_en), .linreg_voltage_code_out(code), .linreg_voltage_mv_out(mvo),
        .boost_gain_divider_out(gain), .boost_skip_elevated_out(skip), .boost_ovp_enable_out(ovp),
        .boost_lowcur_out(lowc), .boost_current_limit_out(lim), .soft_start_active_out(ss_act),
        .boost_switch_enable_out(sw), .boost_feedback_select_out(sel), .tuning_current_ua_out(ua));
    // =========================================================
    // Clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end
    // =========================================================
    // Checking and serial bus tasks
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ph(input logic c, input logic d);
        scl = c;
        sda_m = d;
        repeat (3) @(negedge clk);
    endtask : ph
    task automatic xb(input logic [7:0] v, input logic m);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, v[i]);
            ph(1'b1, v[i]);
            r[i] = sda_w;
        end
        ph(1'b0, m);
        ph(1'b1, m);
        a = sda_w;
    endtask : xb
    task automatic start(input logic [7:0] off);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        xb({ldbc_pkg::DEV_ADDR, 1'b0}, 1'b1);
        chk(12'(a), 12'h000);
        xb(off, 1'b1);
        chk(12'(a), 12'h000);
    endtask : start
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask : stop
    task automatic wr(input logic [7:0] off, input logic [7:0] val);
        start(off);
        xb(val, 1'b1);
        chk(12'(a), 12'h000);
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        start(off);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        xb({ldbc_pkg::DEV_ADDR, 1'b1}, 1'b1);
        chk(12'(a), 12'h000);
        xb(8'hff, 1'b1);
        stop();
        chk(12'(r), 12'(exp));
    endtask : rd
    function automatic logic [1:0] fb_exp();
        logic [1:0] best;
        logic [7:0] lo;
        logic       f;
        best = src;
        lo = 8'h00;
        f = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (auto_sel && src != 2'h0 && mode[2*i+:2] != 2'h0 && !pump[i] && (!f || mv[8*i+:8] < lo)) begin
                f = 1'b1;
                lo = mv[8*i+:8];
                best = 2'(i + 1);
            end
        end
        return best;
    endfunction : fb_exp
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // =========================================================
    // Main sequence
    initial begin
        {rst, scl, sda_m} = 3'h7;  // Reset held, serial lines idle high
        {en, auto_sel, over, src, tune, mode, pump, mv} = 43'h0;
        void'($urandom(20));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(12'({ldo_en, code}), 12'h000);
        chk(mvo, ldbc_pkg::LDO_BASE_MV);
        chk(12'({lowc, ovp, skip, gain}), 12'h004);
        rd(8'h22, 8'h04);
        for (int k = 0; k < 4; k++) begin
            v0 = 8'($urandom);
            v7 = (k == 0) ? 8'h1f : 8'($urandom);
            v22 = (k == 1) ? 8'h00 : 8'($urandom);
            wr(8'h00, v0);
            wr(8'h07, v7);
            wr(8'h22, v22);
            chk(12'(ldo_en), 12'(v0[0]));
            chk(12'(code), 12'(v7[4:0]));
            chk(mvo, 12'(1800 + 50 * v7[4:0]));
            chk(12'({lowc, ovp, skip, gain}), 12'(v22[3:0]));
            rd(8'h07, {3'h0, v7[4:0]});
            rd(8'h00, v0);
            rd(8'h22, {4'h0, v22[3:0]});
        end
        rd(8'h10, 8'h00);
        wr(8'h22, 8'h0c);
        en = 1'b1;
        repeat (2) @(negedge clk);
        chk(12'(ss_act), 12'h001);
        @(negedge clk);
        chk(12'(lim), 12'(ldbc_pkg::LIM_SOFT));
        repeat (SS + 2) @(negedge clk);
        chk(12'({ss_act, lim}), 12'(ldbc_pkg::LIM_REDUCED));
        for (int p = 0; p < 2; p++) begin
            wr(8'h22, p ? 8'h04 : 8'h00);
            chk(12'(lim), 12'(ldbc_pkg::LIM_NORMAL));
            for (int k = 0; k < 40; k++) begin
                {src, auto_sel, mode, pump, tune, over} = 18'($urandom);
                mv = (k < 4) ? 24'h404040 : 24'($urandom);
                @(negedge clk);
                chk(12'(sel), 12'(fb_exp()));
                chk(12'(ua), 12'(tune));
                chk(12'(sw), 12'(!(over && p == 1 && (src != 2'h0 || auto_sel))));
            end
        end
        test_done();
    end
endmodule : tb_ldbc_ctrl
